// >>> src/txrle_encoder.sv
// Operation
// R1: each instance is one channel and decodes its inputs by its own rail mode alone.
// R2: in single-rail mode the framer supplies the whole stream serially on the positive input.
// R3: inputs are sampled on the rising or falling link clock edge as configured.
// R4: single-rail data at DS3 or STS-1 rate is coded to B3ZS.
// R5: single-rail data at E3 rate is coded to HDB3.
// R6: in dual-rail mode a sampled high positive input yields one positive pulse that bit.
// R7: in dual-rail mode a sampled high negative input yields one negative pulse that bit.
// R8: dual-rail requests bypass the coder and pass to the line unchanged.
// R9: in dual-rail mode the framer does the line coding itself.
// R10: the negative input is ignored in single-rail mode and should be held low.
// R11: the link clock times the transmit section and samples both data inputs.
// R12: the framer supplies the link clock at 44.736, 34.368 or 51.84 MHz.
// R13: zero runs become substitution codes with bipolar violations, ones stay AMI.
// R14: positive and negative pulses never share a bit; both requested gives no pulse.
`timescale 1ns/1ps

module txrle_async_fifo #(
   parameter int unsigned WIDTH = 2,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             wr_clk,
   input  wire logic             wr_rst,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             rd_clk,
   input  wire logic             rd_rst,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic [WIDTH-1:0]      rd_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   // width follows the pointer; depth must be a power of two, at least four
   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin;
   logic [AW:0]      wgray;
   logic [AW:0]      rbin;
   logic [AW:0]      rgray;
   logic [AW:0]      rg_meta;
   logic [AW:0]      rg_sync;
   logic [AW:0]      wg_meta;
   logic [AW:0]      wg_sync;

   wire logic         do_wr     = wr_valid & wr_ready;
   wire logic         do_rd     = rd_valid & rd_ready;
   wire logic [AW:0]  next_wbin = wbin + (AW+1)'(do_wr);
   wire logic [AW:0]  next_rbin = rbin + (AW+1)'(do_rd);
   wire logic [AW:0]  full_pat  = {~rg_sync[AW:AW-1], rg_sync[AW-2:0]};

   // pointers cross as gray code so a torn sample is off by one at most
   assign wr_ready = (wgray != full_pat);
   assign rd_valid = (rgray != wg_sync);
   assign rd_data  = mem[rbin[AW-1:0]];

   always_ff @(posedge wr_clk) begin
      if (do_wr) begin
         mem[wbin[AW-1:0]] <= wr_data;
      end
   end

   // write pointer and its gray copy
   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         wbin  <= '0;
         wgray <= '0;
      end else begin
         wbin  <= next_wbin;
         wgray <= to_gray(next_wbin);
      end
   end

   // read pointer enters the write domain on two flops
   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         rg_meta <= '0;
         rg_sync <= '0;
      end else begin
         rg_meta <= rgray;
         rg_sync <= rg_meta;
      end
   end

   // read pointer and its gray copy
   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         rbin  <= '0;
         rgray <= '0;
      end else begin
         rbin  <= next_rbin;
         rgray <= to_gray(next_rbin);
      end
   end

   // write pointer enters the read domain on two flops
   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         wg_meta <= '0;
         wg_sync <= '0;
      end else begin
         wg_meta <= wgray;
         wg_sync <= wg_meta;
      end
   end
endmodule

module txrle_encoder #(
   parameter int unsigned DEPTH = txrle_pkg::FIFO_DEPTH
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  cfg_single_rail,
   input  wire logic                  cfg_rate_e3,
   input  wire logic                  cfg_sample_fall,
   input  wire logic                  tx_line_clock_in,
   input  wire logic                  tx_pos_rail_in,
   input  wire logic                  tx_neg_rail_in,
   output logic                       tx_accept,
   output txrle_pkg::txrle_sym_t      line_sym,
   output logic                       line_valid,
   input  wire logic                  line_ready
);
   // ---------------- link domain ----------------
   logic                  rst_meta;
   logic                  link_rst;
   txrle_pkg::txrle_cfg_t cfg_meta;
   txrle_pkg::txrle_cfg_t cfg;
   logic                  fall_pos;
   logic                  fall_neg;
   logic                  rise_pos;
   logic                  rise_neg;
   logic                  samp_pos;
   logic                  samp_neg;
   logic                  samp_valid;
   txrle_pkg::txrle_tag_t tags [txrle_pkg::PIPE_LEN];
   txrle_pkg::txrle_tag_t next_tags [txrle_pkg::PIPE_LEN];
   logic                  parity;
   logic                  last_pol;
   txrle_pkg::txrle_sym_t enc_sym;
   logic                  enc_valid;
   logic                  fifo_wr_ready;

   wire txrle_pkg::txrle_cfg_t cfg_in = '{single_rail: cfg_single_rail,
                                          rate_e3:     cfg_rate_e3,
                                          sample_fall: cfg_sample_fall};

   // reset level crosses into the link domain on two flops
   always_ff @(posedge tx_line_clock_in) begin
      rst_meta <= rst;
      link_rst <= rst_meta;
   end

   // configuration is quasi-static; the two flops only guard against metastability
   always_ff @(posedge tx_line_clock_in) begin
      cfg_meta <= cfg_in;
      cfg      <= cfg_meta;
   end

   // falling capture is retimed on the next rising edge, half a cycle of slack
   // R3: falling-edge capture
   // R11: link clock samples rails
   always_ff @(negedge tx_line_clock_in) begin
      if (link_rst) begin
         fall_pos <= 1'b0;
         fall_neg <= 1'b0;
      end else begin
         fall_pos <= tx_pos_rail_in;
         fall_neg <= tx_neg_rail_in;
      end
   end

   // R3: rising-edge capture
   always_ff @(posedge tx_line_clock_in) begin
      if (link_rst) begin
         rise_pos <= 1'b0;
         rise_neg <= 1'b0;
      end else begin
         rise_pos <= tx_pos_rail_in;
         rise_neg <= tx_neg_rail_in;
      end
   end

   // R3: edge select
   wire logic pick_pos = cfg.sample_fall ? fall_pos : rise_pos;
   wire logic pick_neg = cfg.sample_fall ? fall_neg : rise_neg;

   always_ff @(posedge tx_line_clock_in) begin
      if (link_rst) begin
         samp_pos <= 1'b0;
         samp_neg <= 1'b0;
      end else begin
         samp_pos <= pick_pos;
         samp_neg <= pick_neg;
      end
   end

   // first link cycle after reset carries no sample yet
   always_ff @(posedge tx_line_clock_in) begin
      if (link_rst) begin
         samp_valid <= 1'b0;
      end else begin
         samp_valid <= 1'b1;
      end
   end

   // R4: three-zero window for B3ZS
   // R5: four-zero window for HDB3
   wire logic zero_run3 = !samp_pos && (tags[0] == txrle_pkg::TXRLE_TAG_ZERO)
                          && (tags[1] == txrle_pkg::TXRLE_TAG_ZERO);
   wire logic zero_run4 = zero_run3 && (tags[2] == txrle_pkg::TXRLE_TAG_ZERO);
   wire logic do_sub    = cfg.rate_e3 ? zero_run4 : zero_run3;
   wire logic add_bpol  = (parity == txrle_pkg::PARITY_EVEN);

   // R13: substitution
   // an even pulse count since the last violation needs a balancing pulse,
   // which gives B0V/00V for B3ZS and B00V/000V for HDB3 from one decision
   always_comb begin
      next_tags[0] = samp_pos ? txrle_pkg::TXRLE_TAG_MARK : txrle_pkg::TXRLE_TAG_ZERO;
      for (int k = 1; k < txrle_pkg::PIPE_LEN; k++) begin
         next_tags[k] = tags[k-1];
      end
      if (do_sub) begin
         next_tags[0] = txrle_pkg::TXRLE_TAG_VIOL;
         if (add_bpol && cfg.rate_e3) begin
            next_tags[txrle_pkg::RUN_HDB3-1] = txrle_pkg::TXRLE_TAG_BPOL;
         end else if (add_bpol) begin
            next_tags[txrle_pkg::RUN_B3ZS-1] = txrle_pkg::TXRLE_TAG_BPOL;
         end
      end
   end

   wire logic next_parity = do_sub ? txrle_pkg::PARITY_EVEN : (parity ^ samp_pos);

   wire logic coder_clr = link_rst || !cfg.single_rail || !samp_valid;

   // R8: coder cleared while bypassed
   always_ff @(posedge tx_line_clock_in) begin
      if (coder_clr) begin
         for (int k = 0; k < txrle_pkg::PIPE_LEN; k++) begin
            tags[k] <= txrle_pkg::TXRLE_TAG_ZERO;
         end
      end else begin
         tags <= next_tags;
      end
   end

   // parity restarts even with the pipeline, so a substitution before any mark carries a B
   always_ff @(posedge tx_line_clock_in) begin
      if (coder_clr) begin
         parity <= txrle_pkg::PARITY_EVEN;
      end else begin
         parity <= next_parity;
      end
   end

   // R13: alternate mark inversion, violation repeats the last polarity
   txrle_pkg::txrle_tag_t head;
   assign head = tags[txrle_pkg::PIPE_LEN-1];
   wire logic head_alt  = (head == txrle_pkg::TXRLE_TAG_MARK)
                          || (head == txrle_pkg::TXRLE_TAG_BPOL);
   wire logic head_viol = (head == txrle_pkg::TXRLE_TAG_VIOL);
   wire logic alt_pol   = ~last_pol;
   wire logic out_pol   = head_viol ? last_pol : alt_pol;
   wire logic head_puls = head_alt || head_viol;

   wire txrle_pkg::txrle_sym_t coded_sym = '{pos: head_puls && (out_pol == txrle_pkg::POL_POS),
                                             neg: head_puls && (out_pol != txrle_pkg::POL_POS)};

   // R6: positive request
   // R7: negative request
   // R14: both high sends nothing
   wire txrle_pkg::txrle_sym_t rail_sym = '{pos: samp_pos && !samp_neg,
                                            neg: samp_neg && !samp_pos};

   // R1: per-channel mode select
   // R10: negative input unused in single-rail
   wire txrle_pkg::txrle_sym_t next_enc = cfg.single_rail ? coded_sym : rail_sym;

   // R13: polarity memory
   always_ff @(posedge tx_line_clock_in) begin
      if (link_rst) begin
         last_pol <= ~txrle_pkg::POL_POS;
      end else if (cfg.single_rail && head_puls) begin
         last_pol <= out_pol;
      end
   end

   always_ff @(posedge tx_line_clock_in) begin
      if (link_rst) begin
         enc_sym   <= '0;
         enc_valid <= 1'b0;
      end else begin
         enc_sym   <= next_enc;
         enc_valid <= samp_valid;
      end
   end

   // accept is a link-domain level and lags the fifo by one link cycle
   always_ff @(posedge tx_line_clock_in) begin
      if (link_rst) begin
         tx_accept <= 1'b0;
      end else begin
         tx_accept <= fifo_wr_ready;
      end
   end

   // ---------------- core domain ----------------
   txrle_pkg::txrle_sym_t fifo_sym;
   logic                  fifo_valid;

   // a symbol dropped at a full fifo breaks the line code, so the driver must keep up
   // output stage keeps line outputs on flops; it takes a word when empty or drained
   wire logic fifo_rd_ready = !line_valid || line_ready;

   txrle_async_fifo #(
      .WIDTH (txrle_pkg::SYM_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .wr_clk   (tx_line_clock_in),
      .wr_rst   (link_rst),
      .wr_valid (enc_valid),
      .wr_ready (fifo_wr_ready),
      .wr_data  (enc_sym),
      .rd_clk   (core_clk),
      .rd_rst   (rst),
      .rd_valid (fifo_valid),
      .rd_ready (fifo_rd_ready),
      .rd_data  (fifo_sym)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_sym   <= '0;
         line_valid <= 1'b0;
      end else if (fifo_rd_ready) begin
         line_sym   <= fifo_valid ? fifo_sym : '0;
         line_valid <= fifo_valid;
      end
   end
endmodule

// >>> src/txrle_pkg.sv
package txrle_pkg;

   // one line symbol: a positive pulse, a negative pulse, or neither
   typedef struct packed {
      logic pos;
      logic neg;
   } txrle_sym_t;

   // channel configuration, held steady by the system side
   typedef struct packed {
      logic single_rail;
      logic rate_e3;
      logic sample_fall;
   } txrle_cfg_t;

   // symbol class inside the coding pipeline
   typedef enum logic [1:0] {
      TXRLE_TAG_ZERO  = 2'b00,
      TXRLE_TAG_MARK  = 2'b01,
      TXRLE_TAG_BPOL  = 2'b10,
      TXRLE_TAG_VIOL  = 2'b11
   } txrle_tag_t;

   localparam int unsigned SYM_W       = 2;
   localparam int unsigned FIFO_DEPTH  = 16;
   localparam int unsigned PIPE_LEN    = 4;
   localparam int unsigned RUN_B3ZS    = 3;
   localparam int unsigned RUN_HDB3    = 4;
   localparam logic        POL_POS     = 1'b1;
   localparam logic        PARITY_EVEN = 1'b0;

   function automatic logic [4:0] bin2gray(input logic [4:0] b);
      return b ^ (b >> 1);
   endfunction

endpackage

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic                  core_clk        = 1'b0;
   logic                  rst             = 1'b1;
   logic                  cfg_single_rail = 1'b0;
   logic                  cfg_rate_e3     = 1'b0;
   logic                  cfg_sample_fall = 1'b0;
   logic                  line_ready      = 1'b1;
   logic                  go              = 1'b0;
   logic [15:0]           pat_p           = 16'h0000;
   logic [15:0]           pat_n           = 16'h0000;
   logic [4:0]            pat_len         = 5'h01;
   wire logic             tx_line_clock_in;
   wire logic             tx_pos_rail_in;
   wire logic             tx_neg_rail_in;
   wire logic             tx_accept;
   wire logic             line_valid;
   txrle_pkg::txrle_sym_t line_sym;
   int                    num_errors      = 0;
   int                    comparisons     = 0;
   txrle_framer_model i_far (.fall(cfg_sample_fall), .go(go), .pat_p(pat_p), .pat_n(pat_n),
      .pat_len(pat_len), .tx_line_clock_in(tx_line_clock_in),
      .tx_pos_rail_in(tx_pos_rail_in), .tx_neg_rail_in(tx_neg_rail_in));
   txrle_encoder i_dut (.core_clk(core_clk), .rst(rst), .cfg_single_rail(cfg_single_rail),
      .cfg_rate_e3(cfg_rate_e3), .cfg_sample_fall(cfg_sample_fall),
      .tx_line_clock_in(tx_line_clock_in), .tx_pos_rail_in(tx_pos_rail_in),
      .tx_neg_rail_in(tx_neg_rail_in), .tx_accept(tx_accept), .line_sym(line_sym),
      .line_valid(line_valid), .line_ready(line_ready));
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic print_verdict();
      if (num_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_sym(input txrle_pkg::txrle_sym_t got, input txrle_pkg::txrle_sym_t exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // a word seen valid at the falling edge is taken at the next rising edge
   task automatic get_sym(output txrle_pkg::txrle_sym_t s);
      int n;
      n = 0;
      @(negedge core_clk);
      while (line_valid !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      if (line_valid !== 1'b1)
         chk_val({7'h00, line_valid}, 8'h01);
      s = line_sym;
   endtask
   task automatic restart(input logic sr, e3, fa, input logic [15:0] pp, pn,
                          input logic [4:0] len);
      @(posedge core_clk);
      #2;
      go = 1'b0;
      rst = 1'b1;
      cfg_single_rail = sr;
      cfg_rate_e3 = e3;
      cfg_sample_fall = fa;
      pat_p = pp;
      pat_n = pn;
      pat_len = len;
      repeat (5) @(posedge tx_line_clock_in);
      @(posedge core_clk);
      #2;
      chk_val({7'h00, tx_accept}, 8'h00);
      chk_val({7'h00, line_valid}, 8'h00);
      rst = 1'b0;
      repeat (4) @(posedge tx_line_clock_in);
      @(posedge core_clk);
      #2;
      go = 1'b1;
   endtask
   task automatic t_dual(input logic fa);
      txrle_pkg::txrle_sym_t s;
      txrle_pkg::txrle_sym_t e;
      logic [3:0]            pp;
      logic [3:0]            pn;
      int                    i;
      pp = 4'h9;
      pn = 4'ha;
      restart(1'b0, 1'b0, fa, {12'h000, pp}, {12'h000, pn}, 5'h04);
      s = '0;
      i = 0;
      while (s === 2'b00 && i < 200) begin
         get_sym(s);
         i++;
      end
      for (i = 0; i < 8; i++) begin
         if (i > 0)
            get_sym(s);
         e.pos = pp[i%4] & ~pn[i%4];
         e.neg = pn[i%4] & ~pp[i%4];
         chk_sym(s, e);
      end
   endtask
   task automatic t_stall();
      @(posedge core_clk);
      #2;
      line_ready = 1'b0;
      repeat (400) @(posedge core_clk);
      #2;
      chk_val({7'h00, tx_accept}, 8'h00);
      chk_val({7'h00, line_valid}, 8'h01);
      line_ready = 1'b1;
      repeat (400) @(posedge core_clk);
      #2;
      chk_val({7'h00, tx_accept}, 8'h01);
   endtask
   // neg rail carries garbage, which single rail must ignore
   task automatic t_single(input logic e3, fa, input logic [15:0] pp, input logic [4:0] len,
                           input logic [7:0] exp_run, input logic exp_viol);
      txrle_pkg::txrle_sym_t s;
      logic                  lp;
      logic [7:0]            run;
      logic [7:0]            maxr;
      logic [7:0]            nv;
      int                    i;
      restart(1'b1, e3, fa, pp, ~pp, len);
      lp = 1'b0;
      run = 8'h00;
      maxr = 8'h00;
      nv = 8'h00;
      for (i = 0; i < 80; i++) begin
         get_sym(s);
         if (s.pos | s.neg) begin
            if (i >= 16 && s.pos == lp)
               nv++;
            lp = s.pos;
            run = 8'h00;
         end else begin
            run++;
            if (i >= 16 && run > maxr)
               maxr = run;
         end
      end
      chk_val(maxr, exp_run);
      chk_val({7'h00, nv != 8'h00}, {7'h00, exp_viol});
   endtask
   initial begin
      #500000;
      num_errors++;
      print_verdict();
   end
   initial begin
      t_dual(1'b0);
      t_stall();
      t_dual(1'b1);
      t_single(1'b0, 1'b0, 16'h0001, 5'h04, 8'h02, 1'b1);
      t_single(1'b0, 1'b1, 16'h0000, 5'h01, 8'h01, 1'b1);
      t_single(1'b1, 1'b0, 16'h0001, 5'h04, 8'h03, 1'b0);
      t_single(1'b1, 1'b1, 16'h0001, 5'h05, 8'h03, 1'b1);
      t_single(1'b1, 1'b0, 16'h0000, 5'h01, 8'h02, 1'b1);
      print_verdict();
   end
endmodule

// >>> testbench/txrle_encoder_asserts.sv
`timescale 1ns/1ps
module txrle_encoder_asserts #(
   parameter int unsigned DEPTH = 16
) (
   input wire logic                  core_clk,
   input wire logic                  rst,
   input wire logic                  cfg_single_rail,
   input wire logic                  cfg_rate_e3,
   input wire logic                  tx_accept,
   input wire txrle_pkg::txrle_sym_t line_sym,
   input wire logic                  line_valid,
   input wire logic                  line_ready
);
   logic [2:0] zrun;
   logic [8:0] stall;
   logic       last_pos;
   logic       odd;
   logic       prev_zero;
   wire logic  xfer  = line_valid & line_ready;
   wire logic  pulse = line_sym.pos | line_sym.neg;
   // a pulse of the same polarity as the last one is a violation
   wire logic  viol  = xfer & pulse & cfg_single_rail & (line_sym.pos == last_pos);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         zrun <= 3'h0;
         stall <= 9'h000;
         last_pos <= 1'b0;
         odd <= 1'b0;
         prev_zero <= 1'b0;
      end else begin
         stall <= line_ready ? 9'h000 : stall + {8'h00, ~&stall};
         if (xfer) begin
            prev_zero <= ~pulse;
            zrun <= pulse ? 3'h0 : zrun + {2'h0, ~&zrun};
         end
         if (xfer & pulse) begin
            last_pos <= line_sym.pos;
            odd <= viol ? 1'b0 : ~odd;
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence stalled_s;
      line_valid && !line_ready;
   endsequence
   sym_exclusive_a: assert property (line_valid |-> !(line_sym.pos && line_sym.neg))
      else $error("both line rails set");
   valid_hold_a: assert property (stalled_s |=> line_valid)
      else $error("line valid dropped while stalled");
   sym_hold_a: assert property (stalled_s |=> $stable(line_sym))
      else $error("line symbol changed while stalled");
   fifo_refuse_a: assert property (stall == 9'h12c |-> !tx_accept)
      else $error("accept still high after long stall");
   b3zs_run_a: assert property (cfg_single_rail && !cfg_rate_e3 |-> zrun < 3'h3)
      else $error("three zeros on line");
   hdb3_run_a: assert property (cfg_single_rail && cfg_rate_e3 |-> zrun < 3'h4)
      else $error("four zeros on line");
   viol_parity_a: assert property (viol |-> odd)
      else $error("even pulse count between violations");
   viol_gap_a: assert property (viol |-> prev_zero)
      else $error("violation not preceded by zero");
endmodule
bind txrle_encoder txrle_encoder_asserts #(.DEPTH(DEPTH)) i_chk (
   .core_clk(core_clk), .rst(rst), .cfg_single_rail(cfg_single_rail),
   .cfg_rate_e3(cfg_rate_e3), .tx_accept(tx_accept), .line_sym(line_sym),
   .line_valid(line_valid), .line_ready(line_ready));

// >>> testbench/txrle_framer_model.sv
`timescale 1ns/1ps
module txrle_framer_model (
   input  wire logic        fall,
   input  wire logic        go,
   input  wire logic [15:0] pat_p,
   input  wire logic [15:0] pat_n,
   input  wire logic [4:0]  pat_len,
   output logic             tx_line_clock_in,
   output logic             tx_pos_rail_in,
   output logic             tx_neg_rail_in
);
   int   idx = 0;
   logic p   = 1'b0;
   logic n   = 1'b0;
   // free running rate clock, phase unrelated to the core clock
   // the bench runs it below line rate, which the logic does not depend on
   initial begin
      tx_line_clock_in = 1'b0;
      tx_pos_rail_in = 1'b0;
      tx_neg_rail_in = 1'b0;
      #7;
      forever #62.5 tx_line_clock_in = ~tx_line_clock_in;
   end
   // pre-coded bit pairs, one per cycle
   always @(tx_line_clock_in) begin
      #1;
      if (tx_line_clock_in == fall) begin
         p = go & pat_p[idx];
         n = go & pat_n[idx];
         idx = (go && idx + 1 < pat_len) ? idx + 1 : 0;
         tx_pos_rail_in = p;
         tx_neg_rail_in = n;
      end else begin
         // hold over: inverse exposes sampling on the wrong edge
         tx_pos_rail_in = ~p;
         tx_neg_rail_in = ~n;
      end
   end
endmodule
